// ===== inc/usart_clk_defines.svh
// constants for the usart clock generator and receive buffer
`ifndef USART_CLK_DEFINES_SVH
`define USART_CLK_DEFINES_SVH
`define ADDR_W          3
`define REG_CTRL        3'h0
`define REG_DIV_LO      3'h1
`define REG_DIV_HI      3'h2
`define REG_DATA        3'h3
`define REG_RXSTAT      3'h4
`define REG_STATUS      3'h5
`define CTRL_SYNC_BIT   0
`define CTRL_DBL_BIT    1
`define CTRL_DIR_BIT    2
`define CTRL_POL_BIT    3
`define RXST_NINTH_BIT  0
`define RXST_OVR_BIT    1
`define RXST_FERR_BIT   2
`define RXST_PERR_BIT   3
`define CTRL_RESET      8'h00
`define DIV_RESET       12'h000
`define DIV_W           12
`define DIV_MAX         12'hFFF
`define PH_NORMAL       5'h10
`define PH_DOUBLE       5'h08
`define PH_SYNC         5'h02
`endif

// ===== inc/usart_clk_pkg.sv
// types for the usart clock generator and receive buffer
package usart_clk_pkg;
  typedef enum logic [1:0] {
    MODE_ASYNC_NORMAL,
    MODE_ASYNC_DOUBLE,
    MODE_SYNC_MASTER,
    MODE_SYNC_SLAVE
  } clk_mode_e;
endpackage

// ===== hw/usart_clk_rxbuf.sv
// usart clock generation, transmit buffer and two-level receive fifo
`timescale 1ns/1ps
`include "usart_clk_defines.svh"

// Functional notes
// - sync mode bit one selects synchronous
// - clock pin direction picks master or slave
// - clock pin idle in asynchronous modes
// - generator for async/master, pin for slave
// - counter reloads at zero or low write
// - one pulse per zero, rate clk/(div+1)
// - transmitter divides by 2, 8 or 16
// - receiver uses 2, 8 or 16 states
// - divisor is twelve bits, high and low
// - double speed only acts when asynchronous
// - double speed gives 8 not 16
// - pin clock synchronised then edge detected
// - two-entry fifo, each data read pops unless empty
// - frame/parity flags and ninth bit stored per entry
// - shift register holds third level when full
// - single transmit buffer allows gapless frames
// - overrun detected, frame and parity errors taken from the receiver inputs
// - polarity bit selects change/sample edges
module usart_clk_rxbuf
  import usart_clk_pkg::*;
#(
  parameter int DATA_W = 9
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic [`ADDR_W-1:0]  addr,
  input  wire logic [7:0]          wrData,
  input  wire logic                wrStb,
  input  wire logic                rdStb,
  output logic      [7:0]          rdData,
  input  wire logic                xferClockPinIn,
  output logic                     xferClockPinOut,
  output logic                     xferClockPinOe,
  output logic                     txBitTick,
  output logic                     rxSampleTick,
  output logic      [4:0]          rxStates,
  output logic                     txChangeEdge,
  output logic                     rxSampleEdge,
  output logic                     txLoad,
  output logic      [DATA_W-1:0]   txShiftData,
  input  wire logic                txShiftReady,
  input  wire logic                rxDone,
  input  wire logic [DATA_W-1:0]   rxData,
  input  wire logic                rxFrameErr,
  input  wire logic                rxParityErr,
  input  wire logic                rxStartSeen
);
  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [7:0]          ctrl_r;
  logic [`DIV_W-1:0]   baudDivisor_r;
  logic                txNinth_r;
  logic                divLowWrite;
  logic                syncModeSelect;
  logic                doubleSpeedSelect;
  logic                xferClockDirection;
  logic                xferClockPolarity;
  clk_mode_e           mode;

  assign divLowWrite        = wrStb && addr == `REG_DIV_LO;
  assign syncModeSelect     = ctrl_r[`CTRL_SYNC_BIT];
  assign doubleSpeedSelect  = ctrl_r[`CTRL_DBL_BIT] && !syncModeSelect;
  assign xferClockDirection = ctrl_r[`CTRL_DIR_BIT];
  assign xferClockPolarity  = ctrl_r[`CTRL_POL_BIT];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r        <= `CTRL_RESET;
      baudDivisor_r <= `DIV_RESET;
      txNinth_r     <= 1'b0;
    end else if (wrStb) begin
      if (addr == `REG_CTRL) begin
        ctrl_r <= wrData;
      end else if (addr == `REG_DIV_LO) begin
        baudDivisor_r[7:0] <= wrData;
      end else if (addr == `REG_DIV_HI) begin
        baudDivisor_r[11:8] <= wrData[3:0];
        txNinth_r           <= wrData[7];
      end
    end
  end

  always_comb begin
    if (!syncModeSelect) begin
      mode = doubleSpeedSelect ? MODE_ASYNC_DOUBLE : MODE_ASYNC_NORMAL;
    end else if (xferClockDirection) begin
      mode = MODE_SYNC_MASTER;
    end else begin
      mode = MODE_SYNC_SLAVE;
    end
  end

  // ---------------------------------------------------------------
  // baud rate generator
  // ---------------------------------------------------------------
  logic [`DIV_W-1:0] baudCount_r;
  logic              baudTick;

  assign baudTick = baudCount_r == '0 && !divLowWrite;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      baudCount_r <= `DIV_RESET;
    end else if (divLowWrite) begin
      baudCount_r <= {baudDivisor_r[11:8], wrData};
    end else if (baudCount_r == '0) begin
      baudCount_r <= baudDivisor_r;
    end else begin
      baudCount_r <= baudCount_r - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // external clock synchroniser and edge detect
  // ---------------------------------------------------------------
  logic xckMeta_r;
  logic xckSync_r;
  logic xckPrev_r;
  logic xckRise;
  logic xckFall;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      xckMeta_r <= 1'b0;
      xckSync_r <= 1'b0;
      xckPrev_r <= 1'b0;
    end else begin
      xckMeta_r <= xferClockPinIn;
      xckSync_r <= xckMeta_r;
      xckPrev_r <= xckSync_r;
    end
  end

  // peer must stay below clk/4 for edges to be seen
  assign xckRise = xckSync_r && !xckPrev_r;
  assign xckFall = !xckSync_r && xckPrev_r;

  // ---------------------------------------------------------------
  // transmitter prescaler and master clock output
  // ---------------------------------------------------------------
  logic [3:0] txDiv_r;
  logic [3:0] txDivTop;
  logic       masterClk_r;
  logic       masterRise;

  always_comb begin
    case (mode)
      MODE_ASYNC_DOUBLE: txDivTop = 4'(`PH_DOUBLE - 5'h01);
      MODE_SYNC_MASTER:  txDivTop = 4'(`PH_SYNC - 5'h01);
      default:           txDivTop = 4'(`PH_NORMAL - 5'h01);
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      txDiv_r <= 4'h0;
    end else if (baudTick && mode != MODE_SYNC_SLAVE) begin
      txDiv_r <= (txDiv_r >= txDivTop) ? 4'h0 : txDiv_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || mode != MODE_SYNC_MASTER) begin
      masterClk_r <= 1'b0;
    end else if (baudTick) begin
      masterClk_r <= !masterClk_r;
    end
  end

  assign masterRise = baudTick && !masterClk_r;
  assign xferClockPinOe  = mode == MODE_SYNC_MASTER;
  assign xferClockPinOut = xferClockPinOe && (masterClk_r ^ xferClockPolarity);

  always_comb begin
    txBitTick    = 1'b0;
    txChangeEdge = 1'b0;
    rxSampleEdge = 1'b0;
    rxSampleTick = 1'b0;
    case (mode)
      MODE_SYNC_SLAVE: begin
        txChangeEdge = xferClockPolarity ? xckFall : xckRise;
        rxSampleEdge = xferClockPolarity ? xckRise : xckFall;
        txBitTick    = txChangeEdge;
        rxSampleTick = rxSampleEdge;
      end
      MODE_SYNC_MASTER: begin
        txChangeEdge = masterRise;
        rxSampleEdge = baudTick && masterClk_r;
        txBitTick    = baudTick && txDiv_r == txDivTop;
        rxSampleTick = baudTick;
      end
      default: begin
        txBitTick    = baudTick && txDiv_r == txDivTop;
        rxSampleTick = baudTick;
      end
    endcase
  end

  always_comb begin
    case (mode)
      MODE_ASYNC_NORMAL: rxStates = `PH_NORMAL;
      MODE_ASYNC_DOUBLE: rxStates = `PH_DOUBLE;
      default:           rxStates = `PH_SYNC;
    endcase
  end

  // ---------------------------------------------------------------
  // transmit write buffer
  // ---------------------------------------------------------------
  logic txFull_r;

  assign txLoad = txFull_r && txShiftReady;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      txFull_r    <= 1'b0;
      txShiftData <= '0;
    end else if (wrStb && addr == `REG_DATA) begin
      txFull_r    <= 1'b1;
      txShiftData <= {txNinth_r, wrData};
    end else if (txLoad) begin
      txFull_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // receive fifo with shift register as third level
  // ---------------------------------------------------------------
  localparam int ENT_W = DATA_W + 3;
  logic [ENT_W-1:0] rxFifo_r [2];
  logic             rdPtr_r;
  logic             wrPtr_r;
  logic [1:0]       rxCount_r;
  logic             held_r;
  logic [ENT_W-1:0] heldEntry_r;
  logic             pop;
  logic             push;
  logic             lostChar;
  logic [ENT_W-1:0] pushEntry;
  logic [ENT_W-1:0] headEntry;

  assign headEntry = rxFifo_r[rdPtr_r];
  assign pop       = rdStb && addr == `REG_DATA && rxCount_r != 2'h0;
  // a new start bit while a character is held and the fifo is full, with no pop that cycle, means overrun
  assign lostChar  = held_r && rxStartSeen && !(pop || rxCount_r != 2'h2);
  assign push      = (rxDone || held_r) && (rxCount_r != 2'h2 || pop);
  assign pushEntry = held_r ? heldEntry_r
                   : {rxParityErr, 1'b0, rxFrameErr, rxData};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdPtr_r     <= 1'b0;
      wrPtr_r     <= 1'b0;
      rxCount_r   <= 2'h0;
      held_r      <= 1'b0;
      heldEntry_r <= '0;
    end else begin
      if (push) begin
        rxFifo_r[wrPtr_r] <= pushEntry;
        wrPtr_r           <= !wrPtr_r;
      end
      if (pop) begin
        rdPtr_r <= !rdPtr_r;
      end
      rxCount_r <= rxCount_r + {1'b0, push} - {1'b0, pop};
      if (held_r && push && rxDone) begin
        heldEntry_r <= {rxParityErr, 1'b0, rxFrameErr, rxData};
      end else if (lostChar) begin
        held_r      <= 1'b0;
        heldEntry_r <= '0;
      end else if (push && held_r) begin
        held_r <= 1'b0;
      end else if (rxDone && !push) begin
        held_r      <= 1'b1;
        heldEntry_r <= {rxParityErr, 1'b0, rxFrameErr, rxData};
      end
    end
  end

  // overrun is flagged with the head fifo entry when a held char is lost, cleared on pop
  logic ovrMark_r;
  always_ff @(posedge clk) begin
    if (!rstn || pop) begin
      ovrMark_r <= 1'b0;
    end else if (lostChar) begin
      ovrMark_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdData <= 8'h00;
    end else if (rdStb) begin
      if (addr == `REG_CTRL) begin
        rdData <= ctrl_r;
      end else if (addr == `REG_DIV_LO) begin
        rdData <= baudDivisor_r[7:0];
      end else if (addr == `REG_DIV_HI) begin
        rdData <= {txNinth_r, 3'h0, baudDivisor_r[11:8]};
      end else if (addr == `REG_DATA) begin
        rdData <= rxCount_r != 2'h0 ? headEntry[7:0] : 8'h00;
      end else if (addr == `REG_RXSTAT) begin
        rdData <= rxCount_r == 2'h0 ? 8'h00 : {4'h0, headEntry[ENT_W-1],
                  headEntry[ENT_W-3], ovrMark_r, headEntry[DATA_W-1]};
      end else if (addr == `REG_STATUS) begin
        rdData <= {3'h0, held_r, txFull_r, 1'b0, rxCount_r};
      end else begin
        rdData <= 8'h00;
      end
    end
  end

endmodule // usart_clk_rxbuf

// ===== test/usart_clk_rxbuf_sva.sv
// concurrent checks on the clock and buffer block
`timescale 1ns/1ps
`include "usart_clk_defines.svh"
module usart_clk_rxbuf_sva (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic               rdStb,
  input wire logic [7:0]         rdData,
  input wire logic               xferClockPinIn,
  input wire logic               xferClockPinOut,
  input wire logic               xferClockPinOe,
  input wire logic               txBitTick,
  input wire logic [4:0]         rxStates,
  input wire logic               txChangeEdge,
  input wire logic               rxSampleEdge,
  input wire logic               txLoad,
  input wire logic               txShiftReady
);
  logic [3:0] pinHist_r;
  always_ff @(posedge clk) begin
    pinHist_r <= {pinHist_r[2:0], xferClockPinIn};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pin_idle: assert property (!xferClockPinOe |-> !xferClockPinOut)
    else $error("pin output high while released");
  a_states_legal: assert property (rxStates inside {5'h10, 5'h08, 5'h02})
    else $error("bad states per bit");
  a_tick_gap: assert property (txBitTick |=> !txBitTick)
    else $error("tx tick two cycles running");
  a_load_ready: assert property (txLoad |-> txShiftReady)
    else $error("load without shift ready");
  a_div_high_zeros: assert property (rdStb && addr == `REG_DIV_HI |=> rdData[6:4] == 3'h0)
    else $error("unused divisor high bits read nonzero");
  a_master_edge: assert property (txChangeEdge && xferClockPinOe
    |=> !xferClockPinOe || $changed(xferClockPinOut))
    else $error("master change edge without pin edge");
  a_load_once: assert property (txLoad |=> !txLoad)
    else $error("load repeated");
  a_reset_clear: assert property ($rose(rstn) |-> !xferClockPinOe && rdData == 8'h00)
    else $error("state not cleared by reset");
  a_edge_apart: assert property (!(txChangeEdge && rxSampleEdge))
    else $error("change and sample on one edge");
  a_slave_sync: assert property ((txChangeEdge || rxSampleEdge) && !xferClockPinOe
    |-> |(pinHist_r[2:0] ^ pinHist_r[3:1]))
    else $error("slave edge without pin edge");
endmodule // usart_clk_rxbuf_sva

// ===== test/serial_peer.sv
// remote peer driving the transfer clock pin
`timescale 1ns/1ps
module serial_peer (
  input  wire logic clk,
  input  wire logic run,
  output logic      pinLvl
);
  logic [1:0] cnt_r;
  // period of 8 cycles, still and low when not running
  always_ff @(posedge clk) begin
    cnt_r  <= run ? cnt_r + 2'h1 : 2'h0;
    pinLvl <= run ? (cnt_r == 2'h3 ? !pinLvl : pinLvl) : 1'b0;
  end
endmodule // serial_peer

// ===== test/usart_clk_rxbuf_tb.sv
// self-checking bench for the clock and buffer block
`timescale 1ns/1ps
`include "usart_clk_defines.svh"
module usart_clk_rxbuf_tb;
  logic               clk, rstn, wrStb, rdStb, run, peerLvl, xferClockPinIn;
  logic [`ADDR_W-1:0] addr;
  logic [7:0]         wrData, rdData;
  logic               xferClockPinOut, xferClockPinOe, txBitTick, rxSampleTick;
  logic [4:0]         rxStates;
  logic               txChangeEdge, rxSampleEdge, txLoad, txShiftReady;
  logic               rxDone, rxFrameErr, rxParityErr, rxStartSeen;
  logic [8:0]         txShiftData, rxData;
  int                 bad_count, comparisons, cyc, n;
  usart_clk_rxbuf dut_u (.clk, .rstn, .addr, .wrData, .wrStb, .rdStb, .rdData,
    .xferClockPinIn, .xferClockPinOut, .xferClockPinOe, .txBitTick, .rxSampleTick,
    .rxStates, .txChangeEdge, .rxSampleEdge, .txLoad, .txShiftData, .txShiftReady,
    .rxDone, .rxData, .rxFrameErr, .rxParityErr, .rxStartSeen);
  serial_peer peer_u (.clk, .run, .pinLvl(peerLvl));
  assign xferClockPinIn = xferClockPinOe ? xferClockPinOut : peerLvl;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude;
    end
  end
  // ----------------
  // access tasks
  // ----------------
  task automatic chk(input string nm, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb  <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg%0d", a), {8'h00, rdData}, {8'h00, e});
  endtask
  task automatic rx(input logic [8:0] d, input logic fe, pe, st);
    @(posedge clk);
    rxDone      <= !st;
    rxStartSeen <= st;
    rxData      <= d;
    rxFrameErr  <= fe;
    rxParityErr <= pe;
    @(posedge clk);
    rxDone      <= 1'b0;
    rxStartSeen <= 1'b0;
  endtask
  task automatic per(input bit t, input int e);
    n = 0;
    do @(negedge clk); while (!(t ? txBitTick : rxSampleTick));
    do begin
      @(negedge clk);
      n++;
    end while (!(t ? txBitTick : rxSampleTick));
    chk("period", 16'(n), 16'(e));
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------
  // tests
  // ----------------
  initial begin
    {rstn, addr, wrData, wrStb, rdStb, run, txShiftReady} = '0;
    {rxDone, rxData, rxFrameErr, rxParityErr, rxStartSeen} = '0;
    {bad_count, comparisons, cyc} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(`REG_STATUS, 8'h00);
    chk("pinOe", {15'h0, xferClockPinOe}, 16'h0);
    rd(3'h7, 8'h00);
    wr(3'h6, 8'hFF);
    $display("reset test done");
    wr(`REG_DIV_HI, 8'h00);
    wr(`REG_DIV_LO, 8'h03);
    per(0, 4);
    chk("states", {11'h0, rxStates}, 16'h10);
    per(1, 64);
    wr(`REG_CTRL, 8'h02);
    per(1, 32);
    chk("states", {11'h0, rxStates}, 16'h08);
    wr(`REG_CTRL, 8'h07);
    per(1, 8);
    chk("pinOe", {15'h0, xferClockPinOe}, 16'h1);
    chk("states", {11'h0, rxStates}, 16'h02);
    wr(`REG_CTRL, 8'h04);
    @(negedge clk);
    chk("pinOe", {15'h0, xferClockPinOe}, 16'h0);
    per(1, 64);
    wr(`REG_DIV_HI, 8'hF1);
    rd(`REG_DIV_HI, 8'h81);
    wr(`REG_DIV_LO, 8'h00);
    per(0, 257);
    wr(`REG_CTRL, 8'h01);
    run <= 1'b1;
    per(1, 8);
    chk("peerLvl", {15'h0, peerLvl}, 16'h1);
    per(0, 8);
    chk("pinOe", {15'h0, xferClockPinOe}, 16'h0);
    wr(`REG_CTRL, 8'h09);
    per(1, 8);
    chk("peerLvl", {15'h0, peerLvl}, 16'h0);
    run <= 1'b0;
    wr(`REG_CTRL, 8'h00);
    $display("clock test done");
    rx(9'h1A5, 1'b1, 1'b0, 1'b0);
    rx(9'h03C, 1'b0, 1'b1, 1'b0);
    rx(9'h0F0, 1'b0, 1'b0, 1'b0);
    rd(`REG_STATUS, 8'h12);
    rd(`REG_RXSTAT, 8'h05);
    rd(`REG_DATA, 8'hA5);
    rd(`REG_STATUS, 8'h02);
    rd(`REG_RXSTAT, 8'h08);
    rd(`REG_DATA, 8'h3C);
    rd(`REG_RXSTAT, 8'h00);
    rd(`REG_DATA, 8'hF0);
    rd(`REG_DATA, 8'h00);
    rx(9'h011, 1'b0, 1'b0, 1'b0);
    rx(9'h022, 1'b0, 1'b0, 1'b0);
    rx(9'h033, 1'b0, 1'b0, 1'b0);
    rx(9'h000, 1'b0, 1'b0, 1'b1);
    rd(`REG_STATUS, 8'h02);
    rd(`REG_RXSTAT, 8'h02);
    rd(`REG_DATA, 8'h11);
    rd(`REG_RXSTAT, 8'h00);
    rd(`REG_DATA, 8'h22);
    rd(`REG_STATUS, 8'h00);
    $display("receive test done");
    wr(`REG_DIV_HI, 8'h80);
    wr(`REG_DATA, 8'h5A);
    rd(`REG_STATUS, 8'h08);
    @(posedge clk);
    txShiftReady <= 1'b1;
    for (n = 0; n < 20 && txLoad !== 1'b1; n++) @(negedge clk);
    chk("txShiftData", {7'h0, txShiftData}, 16'h015A);
    rd(`REG_STATUS, 8'h00);
    $display("transmit test done");
    conclude;
  end
endmodule // usart_clk_rxbuf_tb
bind usart_clk_rxbuf usart_clk_rxbuf_sva sva_u (.clk, .rstn, .addr, .rdStb, .rdData,
  .xferClockPinIn, .xferClockPinOut, .xferClockPinOe, .txBitTick, .rxStates,
  .txChangeEdge, .rxSampleEdge, .txLoad, .txShiftReady);
